/* logic/isl_params.svh */
// Purpose: offsets, field positions and reset values of the slave block
// Assumes: 32-bit wishbone data, registers in the low byte of aligned words
// Notes: definitions only
`ifndef ISL_PARAMS_SVH
`define ISL_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ISL_OFF_CTRL0 8'h00
`define ISL_OFF_STAT 8'h04
`define ISL_OFF_DATA 8'h08
`define ISL_OFF_ADDR 8'h0c
`define ISL_OFF_TOC 8'h10
`define ISL_OFF_PULL 8'h14
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define ISL_CTRL0_RST 8'he0
`define ISL_C0_EN 1
`define ISL_C0_UART 4
`define ISL_C0_DEB 3:2
`define ISL_C0_MODE 7:5
`define ISL_MODE_I2C 3'h6
`define ISL_DEB_NONE 2'h0
`define ISL_DEB_TWO 2'h1
`define ISL_DEB2_CYC 3'h2
`define ISL_DEB4_CYC 3'h4
`define ISL_LAST_BIT 4'h7
`define ISL_BITS 4'h8
// ----------------------------------------
// least system clock, kHz, per debounce
// ----------------------------------------
`define ISL_STD_KHZ_0 2000
`define ISL_STD_KHZ_2 4000
`define ISL_STD_KHZ_4 8000
`define ISL_FAST_KHZ_0 5000
`define ISL_FAST_KHZ_2 10000
`define ISL_FAST_KHZ_4 20000
`endif

/* logic/isl_pkg.sv */
// Purpose: shared types of the slave block
// Assumes: nothing
// Notes: constants live in isl_params.svh
package isl_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK_A, ST_RX, ST_ACK_RX, ST_TX, ST_ACK_TX}
    isl_state_e;
  typedef logic [7:0] isl_byte_t;
endpackage

/* logic/isl_slave.sv */
// Purpose: two-wire bus slave with wishbone register access
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes: scl is never stretched; received bytes queue in a small fifo
//
// What this block does
// RULE1: bus pins only pulled low through enables, never driven high.
// RULE2: slave only, transmitting to or receiving from the master.
// RULE3: no select pin; only a matching address selects this slave.
// RULE4: incoming scl filtered over none, two or four system clocks.
// RULE5: standard rate needs clock above 2, 4 or 8 MHz per debounce.
// RULE6: fast rate needs clock above 5, 10 or 20 MHz per debounce.
// RULE7: every sent or received byte passes through the data register.
// RULE8: data register shared with the other serial mode, no reset value.
// RULE9: address register bits 7..1 hold the own address compared on the bus.
// RULE10: address bit 0 is a free read/write spare bit.
// RULE11: address register aliases the other mode's control and resets to zero.
// RULE12: status, data, address and timeout registers exist only in this mode.
// RULE13: pull-up control stays writable while the bus function runs.
// RULE14: bus mode chosen only with uart select low and mode field 110.
// RULE15: debounce 00 none, 01 two clocks, 10 and 11 four clocks.
// RULE16: done flag low during a byte, high when eight bits complete.
// RULE17: direction flag high when master reads, low when master writes.
// RULE18: first seven bits compared after start, eighth taken as direction.
//
// Added by the designer: the register offsets and the Wishbone register port.
`include "isl_params.svh"

module isl_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset
  input wire logic in_valid_i, // push request
  output logic in_ready_o, // room left
  input wire logic [W-1:0] in_data_i, // pushed word
  output logic out_valid_o, // word waiting
  input wire logic out_ready_i, // consumer takes word
  output logic [W-1:0] out_data_o // oldest word
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  if (D < 1) $error("fifo depth must be at least one");

  assign in_ready_o = cnt_q != (AW + 1)'(D);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rp_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= nxt(wp_q);
      end
      if (pop)
      begin
        rp_q <= nxt(rp_q);
      end
      cnt_q <= (AW + 1)'(cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
    end
  end
endmodule

module isl_slave #(
  parameter int CLK_KHZ = 40000,
  parameter int RX_DEPTH = 4
) (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic rst_i, // sync reset, high
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic wb_we_i, // write
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  output isl_pkg::isl_byte_t wb_dat_lo_o, // read data, low byte
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic scl_i, // bus clock pin level
  input wire logic sda_i, // bus data pin level
  output logic scl_o, // bus clock drive value
  output logic scl_oe_o, // bus clock pull-low enable
  output logic sda_o, // bus data drive value
  output logic sda_oe_o, // bus data pull-low enable
  output logic pullup_scl_o, // internal pull-up on clock pin
  output logic pullup_sda_o, // internal pull-up on data pin
  output logic byte_done_o // pulse: eight bits completed
);
  import isl_pkg::*;

  if (CLK_KHZ <= `ISL_STD_KHZ_4) $error("clock too slow for four-clock debounce");
  if (RX_DEPTH < 1) $error("receive depth must be at least one");

  logic [7:0] ctrl0_q, addr_q, toc_q, data_q;
  logic htx_q, txak_q, wake_q, unread_q, en_q, wb_ack_q;
  logic [1:0] pull_q;
  logic [31:0] rdat_q;
  logic scl_m, scl_s, sda_m, sda_s, sda_q, scl_f, scl_fq;
  logic [2:0] deb_cnt_q;
  isl_state_e st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic sda_oe_q, transfer_done_flag_q, haas_q, hbb_q, master_direction_flag_q, rxak_q;
  logic match_q, ack_ok_q, push_q, done_q;
  logic i2c_sel, i2c_on, en_rise, wr_w, rd_w, rise_w, fall_w, start_w, stop_w;
  logic fifo_rdy, fifo_vld, drain;
  logic [7:0] fifo_dout;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] deb_need(input logic [1:0] s);
    if (s == `ISL_DEB_NONE) return 3'h0;
    else if (s == `ISL_DEB_TWO) return `ISL_DEB2_CYC;
    else return `ISL_DEB4_CYC; // [RULE15]
  endfunction

  function automatic int min_khz(input logic [1:0] s, input logic fast);
    if (s == `ISL_DEB_NONE) return fast ? `ISL_FAST_KHZ_0 : `ISL_STD_KHZ_0;
    else if (s == `ISL_DEB_TWO) return fast ? `ISL_FAST_KHZ_2 : `ISL_STD_KHZ_2;
    else return fast ? `ISL_FAST_KHZ_4 : `ISL_STD_KHZ_4;
  endfunction

  assign i2c_sel = !ctrl0_q[`ISL_C0_UART] && ctrl0_q[`ISL_C0_MODE] == `ISL_MODE_I2C; // [RULE14]
  assign i2c_on = i2c_sel && ctrl0_q[`ISL_C0_EN];
  assign en_rise = ctrl0_q[`ISL_C0_EN] && !en_q;
  assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_q && wb_sel_i[0];
  assign rd_w = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_q;
  assign drain = fifo_vld && !unread_q && !(wr_w && wb_adr_i == `ISL_OFF_DATA);

  // ----------------------------------------
  // pin synchronisers and scl debounce
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  // a glitch shorter than the window never reaches the bit engine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_f <= 1'b1;
      scl_fq <= 1'b1;
      deb_cnt_q <= 3'h0;
    end
    else
    begin
      scl_fq <= scl_f;
      if (scl_s == scl_f)
      begin
        deb_cnt_q <= 3'h0;
      end
      else if (deb_need(ctrl0_q[`ISL_C0_DEB]) == 3'h0 ||
               deb_cnt_q == 3'(deb_need(ctrl0_q[`ISL_C0_DEB]) - 3'h1))
      begin
        scl_f <= scl_s; // [RULE4]
        deb_cnt_q <= 3'h0;
      end
      else
      begin
        deb_cnt_q <= 3'(deb_cnt_q + 3'h1);
      end
    end
  end

  assign rise_w = scl_f && !scl_fq;
  assign fall_w = !scl_f && scl_fq;
  assign start_w = scl_f && scl_fq && sda_q && !sda_s;
  assign stop_w = scl_f && scl_fq && !sda_q && sda_s;

  // ----------------------------------------
  // bit engine and bus status
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || en_rise)
    begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      sda_oe_q <= 1'b0;
      transfer_done_flag_q <= 1'b1;
      haas_q <= 1'b0;
      hbb_q <= 1'b0;
      master_direction_flag_q <= 1'b0;
      rxak_q <= 1'b1;
      match_q <= 1'b0;
      ack_ok_q <= 1'b0;
      push_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      done_q <= 1'b0;
      if (!i2c_on)
      begin
        st_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else if (start_w)
      begin
        st_q <= ST_ADDR; // [RULE18]
        bit_q <= 4'h0;
        hbb_q <= 1'b1;
        haas_q <= 1'b0;
        transfer_done_flag_q <= 1'b0; // [RULE16]
        sda_oe_q <= 1'b0;
      end
      else if (stop_w)
      begin
        st_q <= ST_IDLE;
        hbb_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end
      else if (rise_w)
      begin
        case (st_q)
          ST_ADDR, ST_RX:
          begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= 4'(bit_q + 4'h1);
            if (bit_q == `ISL_LAST_BIT && st_q == ST_ADDR)
            begin
              match_q <= sh_q[6:0] == addr_q[7:1]; // [RULE3] [RULE9] [RULE18]
              if (sh_q[6:0] == addr_q[7:1])
              begin
                master_direction_flag_q <= sda_s; // [RULE17] [RULE18]
                transfer_done_flag_q <= 1'b1;
                done_q <= 1'b1;
              end
            end
            else if (bit_q == `ISL_LAST_BIT)
            begin
              transfer_done_flag_q <= 1'b1; // [RULE16]
              done_q <= 1'b1;
              push_q <= fifo_rdy; // [RULE7]
              ack_ok_q <= fifo_rdy && !txak_q;
            end
          end
          ST_TX:
          begin
            bit_q <= 4'(bit_q + 4'h1);
            if (bit_q == `ISL_LAST_BIT)
            begin
              transfer_done_flag_q <= 1'b1; // [RULE16]
              done_q <= 1'b1;
            end
          end
          ST_ACK_TX:
          begin
            rxak_q <= sda_s;
          end
          default:
          begin
          end
        endcase
      end
      else if (fall_w)
      begin
        case (st_q)
          ST_ADDR:
          begin
            if (bit_q == `ISL_BITS)
            begin
              st_q <= match_q ? ST_ACK_A : ST_IDLE; // [RULE3]
              haas_q <= match_q;
              sda_oe_q <= match_q; // [RULE1]
            end
          end
          ST_ACK_A:
          begin
            bit_q <= 4'h0;
            transfer_done_flag_q <= 1'b0;
            if (master_direction_flag_q)
            begin
              st_q <= ST_TX; // [RULE2]
              sh_q <= data_q; // [RULE7]
              sda_oe_q <= !data_q[7];
            end
            else
            begin
              st_q <= ST_RX; // [RULE2]
              sda_oe_q <= 1'b0;
            end
          end
          ST_RX:
          begin
            if (bit_q == `ISL_BITS)
            begin
              st_q <= ST_ACK_RX;
              sda_oe_q <= ack_ok_q;
            end
          end
          ST_ACK_RX:
          begin
            st_q <= ST_RX;
            bit_q <= 4'h0;
            transfer_done_flag_q <= 1'b0;
            sda_oe_q <= 1'b0;
          end
          ST_TX:
          begin
            if (bit_q == `ISL_BITS)
            begin
              st_q <= ST_ACK_TX;
              sda_oe_q <= 1'b0;
            end
            else
            begin
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= !sh_q[6]; // [RULE1]
            end
          end
          ST_ACK_TX:
          begin
            if (!rxak_q)
            begin
              st_q <= ST_TX;
              bit_q <= 4'h0;
              transfer_done_flag_q <= 1'b0;
              sh_q <= data_q;
              sda_oe_q <= !data_q[7];
            end
            else
            begin
              st_q <= ST_IDLE;
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // receive queue; stalls by refusing the ack when full
  // ----------------------------------------
  isl_fifo #(.W(8), .D(RX_DEPTH)) i_isl_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(push_q),
    .in_ready_o(fifo_rdy),
    .in_data_i(sh_q),
    .out_valid_o(fifo_vld),
    .out_ready_i(drain), // pop only when the byte really lands in the data register
    .out_data_o(fifo_dout)
  );

  // ----------------------------------------
  // wishbone slave and registers
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_q <= 1'b0;
      en_q <= 1'b0;
    end
    else
    begin
      wb_ack_q <= wb_cyc_i && wb_stb_i && !wb_ack_q;
      en_q <= ctrl0_q[`ISL_C0_EN];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl0_q <= `ISL_CTRL0_RST;
      addr_q <= 8'h00; // [RULE11]
      toc_q <= 8'h00;
      htx_q <= 1'b0;
      txak_q <= 1'b0;
      wake_q <= 1'b0;
      pull_q <= 2'h0;
    end
    else if (wr_w)
    begin
      if (wb_adr_i == `ISL_OFF_CTRL0)
      begin
        ctrl0_q <= wb_dat_i[7:0];
      end
      else if (wb_adr_i == `ISL_OFF_PULL)
      begin
        pull_q <= wb_dat_i[1:0]; // [RULE13]
      end
      else if (i2c_sel && wb_adr_i == `ISL_OFF_STAT) // [RULE12]
      begin
        htx_q <= wb_dat_i[4];
        txak_q <= wb_dat_i[3];
        wake_q <= wb_dat_i[1];
      end
      else if (i2c_sel && wb_adr_i == `ISL_OFF_ADDR)
      begin
        addr_q <= wb_dat_i[7:0]; // [RULE9] [RULE10] [RULE11]
      end
      else if (i2c_sel && wb_adr_i == `ISL_OFF_TOC)
      begin
        toc_q <= wb_dat_i[7:0];
      end
    end
  end

  // no reset: content after power-up is unknown by design
  always_ff @(posedge clk_i)
  begin
    if (wr_w && i2c_sel && wb_adr_i == `ISL_OFF_DATA)
    begin
      data_q <= wb_dat_i[7:0]; // [RULE7] [RULE8]
    end
    else if (drain)
    begin
      data_q <= fifo_dout; // [RULE7]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      unread_q <= 1'b0;
    end
    else if (drain)
    begin
      unread_q <= 1'b1;
    end
    else if (rd_w && wb_adr_i == `ISL_OFF_DATA)
    begin
      unread_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdat_q <= 32'h0;
    end
    else
    begin
      rdat_q <= 32'h0;
      if (rd_w && wb_adr_i == `ISL_OFF_CTRL0)
      begin
        rdat_q[7:0] <= ctrl0_q;
      end
      else if (rd_w && wb_adr_i == `ISL_OFF_PULL)
      begin
        rdat_q[7] <= CLK_KHZ > min_khz(ctrl0_q[`ISL_C0_DEB], 1'b1); // [RULE6]
        rdat_q[6] <= CLK_KHZ > min_khz(ctrl0_q[`ISL_C0_DEB], 1'b0); // [RULE5]
        rdat_q[1:0] <= pull_q;
      end
      else if (rd_w && i2c_sel && wb_adr_i == `ISL_OFF_STAT) // [RULE12]
      begin
        rdat_q[7:0] <= {transfer_done_flag_q, haas_q, hbb_q, htx_q, txak_q,
                        master_direction_flag_q, wake_q, rxak_q};
      end
      else if (rd_w && i2c_sel && wb_adr_i == `ISL_OFF_DATA)
      begin
        rdat_q[7:0] <= data_q;
      end
      else if (rd_w && i2c_sel && wb_adr_i == `ISL_OFF_ADDR)
      begin
        rdat_q[7:0] <= addr_q;
      end
      else if (rd_w && i2c_sel && wb_adr_i == `ISL_OFF_TOC)
      begin
        rdat_q[7:0] <= toc_q;
      end
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_dat_lo_o = rdat_q[7:0];
  assign wb_ack_o = wb_ack_q;
  assign sda_oe_o = sda_oe_q;
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign scl_oe_o = 1'b0;
  assign pullup_scl_o = pull_q[0];
  assign pullup_sda_o = pull_q[1];
  assign byte_done_o = done_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_wb_ack;
    s_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack not one cycle after request");

  property p_open_drain;
    !sda_o && !scl_o && !scl_oe_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("bus pin driven high"); // [RULE1]

  property p_mismatch;
    (i2c_on && !en_rise && rise_w && !start_w && !stop_w && st_q == ST_ADDR
      && bit_q == `ISL_LAST_BIT && sh_q[6:0] != addr_q[7:1])
      |=> !transfer_done_flag_q ##1 !haas_q;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("foreign address selected"); // [RULE3]

  property p_match;
    (i2c_on && !en_rise && rise_w && !start_w && !stop_w && st_q == ST_ADDR
      && bit_q == `ISL_LAST_BIT && sh_q[6:0] == addr_q[7:1])
      |=> transfer_done_flag_q && byte_done_o && master_direction_flag_q == $past(sda_s);
  endproperty
  a_match: assert property (p_match) else $error("own address not taken"); // [RULE9] [RULE18]

  property p_deb4;
    (ctrl0_q[`ISL_C0_DEB] != `ISL_DEB_NONE && ctrl0_q[`ISL_C0_DEB] != `ISL_DEB_TWO
      && $stable(ctrl0_q) && $rose(scl_f)) |-> $past(scl_s, 2) && $past(scl_s, 4);
  endproperty
  a_deb4: assert property (p_deb4) else $error("scl passed debounce too early"); // [RULE4] [RULE15]

  property p_drain;
    drain |=> unread_q && data_q == $past(fifo_dout);
  endproperty
  a_drain: assert property (p_drain) else $error("received byte not in data register"); // [RULE7]

  property p_mode_off;
    !i2c_on |=> !sda_oe_o;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("bus driven outside bus mode"); // [RULE14]

  property p_start;
    (i2c_on && start_w && !en_rise) |=> !transfer_done_flag_q && hbb_q && st_q == ST_ADDR;
  endproperty
  a_start: assert property (p_start) else $error("start not seen"); // [RULE16]

  property p_dir;
    (i2c_on && !en_rise && fall_w && !start_w && !stop_w && st_q == ST_ACK_A)
      |=> (st_q == ST_TX) == $past(master_direction_flag_q);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not followed"); // [RULE2] [RULE17]
endmodule

/* tb/isl_master.sv */
// Purpose: behavioural two-wire bus master that drives the slave's pins
// Assumes: bench clock of 25 ns, scl period of 8 clocks (200 ns)
// Notes: both lines are open drain with pull-ups, so a released line reads high
module isl_master (
  input wire logic clk_i, // bench clock
  input wire logic sda_i, // resolved data line
  output logic scl_low_o, // pull clock line low
  output logic sda_low_o // pull data line low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  // low 5, high 3: data moves late in the low phase, so a lagging filter never
  // sees sda move under a clock that it still takes as high
  task automatic bit_clk(input logic b, output logic s);
    scl_low_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_low_o <= ~b;
    @(posedge clk_i);
    scl_low_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    s = sda_i;
  endtask
  task automatic start();
    sda_low_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // long high before sda rises: a four-clock filter must see scl high first
  task automatic stop();
    scl_low_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_low_o <= 1'b1;
    @(posedge clk_i);
    scl_low_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    sda_low_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // ----------------------------------------
  // bytes, msb first
  // ----------------------------------------
  task automatic send(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_clk(b[i], s);
    bit_clk(1'b1, nak);
  endtask
  task automatic recv(input logic nak, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_clk(1'b1, s);
      b[i] = s;
    end
    bit_clk(nak, s);
  endtask
endmodule

/* tb/isl_slave_tb.sv */
// Purpose: self-checking bench of the two-wire slave
// Assumes: 40 MHz clock, bench master on the pins, wishbone register access
// Notes: random data from a fixed seed; corner cases written by hand
`include "isl_params.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module isl_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import isl_pkg::*;
  logic clk_i, rst_i, wb_we, wb_cyc, wb_stb, nak, scl_low, sda_low, scl_w, sda_w;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, wb_dat_o;
  logic [3:0] wb_sel;
  logic wb_ack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, pullup_scl_o, pullup_sda_o, byte_done_o;
  isl_byte_t wb_dat_lo_o, r, v, tx;
  isl_byte_t q [6];
  logic [6:0] own;
  int bad_count = 0, compares = 0, done_n = 0, cyc_n = 0, done_base;
  localparam logic [7:0] BAD [3] = '{8'hd2, 8'ha2, 8'he2};
  assign scl_w = ~scl_low;
  assign sda_w = ~(sda_low | sda_oe_o);
  isl_slave #(.CLK_KHZ(40000), .RX_DEPTH(4)) i_isl_slave (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_lo_o(wb_dat_lo_o),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pullup_scl_o(pullup_scl_o),
    .pullup_sda_o(pullup_sda_o), .byte_done_o(byte_done_o));
  isl_master i_isl_master (.clk_i(clk_i), .sda_i(sda_w), .scl_low_o(scl_low),
    .sda_low_o(sda_low));
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (byte_done_o === 1'b1) done_n <= done_n + 1;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic isl_byte_t c0(input logic [2:0] m, input logic u, input logic [1:0] d);
    return {m, u, d, 1'b1, 1'b0};
  endfunction
  task automatic conclude();
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input isl_byte_t d, output isl_byte_t rd);
    int n;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= {24'($urandom), d};
    wb_sel <= {3'($urandom), 1'b1};
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_lo_o;
    `CHK(wb_dat_o[31:8], 24'h0)
    if (n >= 40) bad_count++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 12000)
    begin
      bad_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_i = 1'b1;
    {wb_we, wb_cyc, wb_stb, wb_adr, wb_dat, wb_sel} = '0;
    void'($urandom(85326));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, `ISL_OFF_CTRL0, 0, r); `CHK(r, 8'he0)
    wb(0, `ISL_OFF_STAT, 0, r); `CHK(r, 8'h00)
    wb(0, `ISL_OFF_PULL, 0, r); `CHK(r, 8'hc0)
    foreach (BAD[i])
    begin
      wb(1, `ISL_OFF_CTRL0, BAD[i], r);
      wb(1, `ISL_OFF_ADDR, 8'hff, r);
      wb(0, `ISL_OFF_STAT, 0, r); `CHK(r, 8'h00)
    end
    wb(1, `ISL_OFF_CTRL0, c0(3'h6, 1'b0, 2'h0), r);
    wb(0, `ISL_OFF_STAT, 0, r); `CHK(r, 8'h81)
    // flags ignore writes, control bits keep them
    wb(1, `ISL_OFF_STAT, 8'hff, r);
    wb(0, `ISL_OFF_STAT, 0, r); `CHK(r, 8'h9b)
    wb(1, `ISL_OFF_STAT, 8'h00, r);
    v = 8'($urandom);
    wb(1, `ISL_OFF_TOC, v, r);
    wb(0, `ISL_OFF_TOC, 0, r); `CHK(r, v)
    wb(0, `ISL_OFF_ADDR, 0, r); `CHK(r, 8'h00)
    own = 7'($urandom);
    v = {own, 1'($urandom)};
    wb(1, `ISL_OFF_ADDR, v, r);
    wb(0, `ISL_OFF_ADDR, 0, r); `CHK(r, v)
    wb(1, `ISL_OFF_PULL, 8'h03, r);
    wb(0, `ISL_OFF_PULL, 0, r); `CHK(r, 8'hc3)
    `CHK({pullup_scl_o, pullup_sda_o}, 2'b11)
    wb(0, 8'h18, 0, r); `CHK(r, 8'h00)
    // receive one byte, debounce off and two clocks
    for (int ds = 0; ds < 2; ds++)
    begin
      wb(1, `ISL_OFF_CTRL0, c0(3'h6, 1'b0, 2'(ds)), r);
      tx = 8'($urandom);
      done_base = done_n;
      i_isl_master.start();
      i_isl_master.send({own, 1'b0}, nak); `CHK(nak, 1'b0)
      wb(0, `ISL_OFF_STAT, 0, r); `CHK({r[7:5], r[2]}, 4'b1110)
      i_isl_master.send(tx, nak); `CHK(nak, 1'b0)
      i_isl_master.stop();
      `CHK(done_n - done_base, 2)
      wb(0, `ISL_OFF_DATA, 0, r); `CHK(r, tx)
    end
    // one address bit wrong: never selected
    done_base = done_n;
    i_isl_master.start();
    i_isl_master.send({own ^ 7'(7'h1 << ($urandom % 7)), 1'b0}, nak); `CHK(nak, 1'b1)
    i_isl_master.send(8'h5a, nak); `CHK(nak, 1'b1)
    i_isl_master.stop();
    `CHK(done_n - done_base, 0)
    // slave transmit
    tx = 8'($urandom);
    wb(1, `ISL_OFF_DATA, tx, r);
    i_isl_master.start();
    i_isl_master.send({own, 1'b1}, nak); `CHK(nak, 1'b0)
    wb(0, `ISL_OFF_STAT, 0, r); `CHK({r[7:5], r[2]}, 4'b1111)
    i_isl_master.recv(1'b1, v); `CHK(v, tx)
    i_isl_master.stop();
    // four-clock debounce swallows the 3-clock highs of a 200 ns clock
    for (int ds = 2; ds < 4; ds++)
    begin
      wb(1, `ISL_OFF_CTRL0, c0(3'h6, 1'b0, 2'(ds)), r);
      done_base = done_n;
      i_isl_master.start();
      i_isl_master.send({own, 1'b0}, nak); `CHK(nak, 1'b1)
      i_isl_master.stop();
      `CHK(done_n - done_base, 0)
    end
    // fill the receive path until it refuses, then drain it in order
    wb(1, `ISL_OFF_CTRL0, c0(3'h6, 1'b0, 2'h0), r);
    i_isl_master.start();
    i_isl_master.send({own, 1'b0}, nak);
    for (int i = 0; i < 6; i++)
    begin
      q[i] = 8'($urandom);
      i_isl_master.send(q[i], nak); `CHK(nak, 1'(i == 5))
    end
    i_isl_master.stop();
    for (int i = 0; i < 5; i++)
    begin
      wb(0, `ISL_OFF_DATA, 0, r); `CHK(r, q[i])
    end
    `CHK({scl_o, scl_oe_o, sda_o}, 3'b000)
    conclude();
  end
endmodule
